// ---- design/reset_seq_pkg.sv ----
// constants and types shared by the reset source sequencer
package reset_seq_pkg;

   // reset values loaded into the core registers
   localparam logic [7:0] PC_LOW_RESET       = 8'h00;
   localparam logic [7:0] WDOG_SETTING_RESET = 8'h07;
   localparam logic [7:0] IRQ_CTRL_RESET     = 8'h00;
   localparam logic [7:0] COUNT_VALUE_RESET  = 8'h00;
   localparam logic [7:0] COUNT_CTRL_RESET   = 8'h40;
   localparam logic [7:0] PORT_RESET      = 8'hff;
   localparam logic [7:0] PRESCALE_RESET  = 8'h00;
   localparam logic [2:0] SP_TOP          = 3'h0;
   localparam logic [2:0] SP_CLEAR        = 3'h0;

   // start_delay_time and its cycle count at the 25 MHz system clock
   localparam int START_DELAY_NS     = 41000;
   localparam int CLK_PERIOD_NS      = 40;
   localparam int START_DELAY_CYCLES =
      (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_HOLD  = 3'b001,
      ST_DELAY = 3'b010,
      ST_RUN   = 3'b100
   } seqState_type;

   typedef enum logic [5:0] {
      KIND_POR      = 6'h01,
      KIND_PIN_RUN  = 6'h02,
      KIND_PIN_HALT = 6'h04,
      KIND_LOWV      = 6'h08,
      KIND_WDOG_RUN  = 6'h10,
      KIND_WDOG_HALT = 6'h20
   } resetKind_type;

   typedef struct packed {
      logic [7:0] pcLow;
      logic [2:0] sp;
      logic [7:0] wdogSetting;
      logic [7:0] irqCtrl;
      logic [7:0] count0;
      logic [7:0] count0Ctrl;
      logic [7:0] count1;
      logic [7:0] count1Ctrl;
      logic [7:0] portA;
      logic [7:0] portADir;
      logic [7:0] prescale;
   } regValues_type;

   typedef struct packed {
      logic core;
      logic wdogSetting;
      logic timers;
      logic ports;
      logic irqCtrl;
      logic prescale;
   } loadMask_type;

   // expired is the upper status bit, powerdown the lower
   typedef struct packed {
      logic expired;
      logic powerdown;
   } statusFlags_type;

   localparam loadMask_type MASK_ALL  = 6'h3f;
   localparam loadMask_type MASK_CORE = 6'h20;

endpackage : reset_seq_pkg

// ---- design/clear_pin_sync.sv ----
// two-stage synchroniser for the external clear pin
`timescale 1ns/1ps
module clear_pin_sync (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic pinN,
   output logic      pinSyncN
);
   logic stage1;

   // held low in reset so the pin reads as asserted until sampled
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stage1   <= 1'b0;
         pinSyncN <= 1'b0;
      end else begin
         stage1   <= pinN;
         pinSyncN <= stage1;
      end
   end
endmodule : clear_pin_sync

// ---- design/reset_source_sequencer.sv ----
// reset source sequencer: reset kinds, start delay, flags, reset values
// Function
// - Power-on sets all port data and direction registers to ones.
// - Hold operation while clear pin low, then wait start delay.
// - Clear pin low while running restarts execution from address zero.
// - Watchdog time-out while running acts as pin reset, sets expired.
// - Watchdog time-out in power-down clears PC and SP, sets expired.
// - Flags: power-on clears, pin keeps when running (sets 01 in power-down), watchdog sets per mode.
// - Power-on leaves every interrupt source disabled.
// - After reset the watchdog is cleared and restarts counting.
// - Power-on turns timers off and clears the timer prescaler.
// - Power-on sets the stack pointer to the top of stack.
// - All resets clear PC low; watchdog setting loads except watchdog halt wake.
// - Timer counts and controls load except on watchdog halt wake.
// - Status top bits: 00, 1u, uu, 01, 11 per reset kind.
`timescale 1ns/1ps
module reset_source_sequencer
   import reset_seq_pkg::*;
#(
   parameter int DELAY_CYCLES = START_DELAY_CYCLES
) (
   input  wire logic      clk,
   input  wire logic      resetn,
   input  wire logic      externalClearPinN,
   input  wire logic      lowVoltageTrip,
   input  wire logic      watchdogTimeout,
   input  wire logic      powerDownMode,
   input  wire logic      haltEnter,
   input  wire logic      flagClear,
   output logic           coreRun,
   output logic           resetLoad,
   output logic           watchdogClear,
   output loadMask_type   loadMask,
   output regValues_type  regValues,
   output statusFlags_type statusFlags,
   output resetKind_type  resetKind
);
   localparam int CW = $clog2(DELAY_CYCLES + 1);
   localparam logic [CW-1:0] DELAY_LAST = CW'(DELAY_CYCLES - 1);

   seqState_type  state;
   logic [CW-1:0] delayCount;
   logic          pinHigh;
   logic          pinEvent;
   logic          tripEvent;
   logic          wdogEvent;
   logic          delayDone;
   resetKind_type next_kind;

   clear_pin_sync u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .pinN     (externalClearPinN),
      .pinSyncN (pinHigh)
   );

   assign pinEvent  = (state == ST_RUN) && !pinHigh;
   assign tripEvent = (state == ST_RUN) && pinHigh && lowVoltageTrip;
   assign wdogEvent = (state == ST_RUN) && pinHigh && !lowVoltageTrip
                      && watchdogTimeout;
   // a pin dropping on the last count must not leak a load pulse
   assign delayDone = (state == ST_DELAY) && pinHigh
                      && (delayCount == DELAY_LAST);

   always_comb begin
      next_kind = resetKind;
      if (pinEvent)
         next_kind = powerDownMode ? KIND_PIN_HALT : KIND_PIN_RUN;
      else if (tripEvent)
         next_kind = KIND_LOWV;
      else if (wdogEvent)
         next_kind = powerDownMode ? KIND_WDOG_HALT : KIND_WDOG_RUN;
   end

   // sequencing; watchdog resets skip the hold and go straight to delay
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_HOLD;
      end else begin
         case (state)
            ST_HOLD: begin
               if (pinHigh && !lowVoltageTrip)
                  state <= ST_DELAY;
            end
            ST_DELAY: begin
               if (!pinHigh)
                  state <= ST_HOLD;
               else if (delayDone)
                  state <= ST_RUN;
            end
            ST_RUN: begin
               if (pinEvent || tripEvent)
                  state <= ST_HOLD;
               else if (wdogEvent)
                  state <= ST_DELAY;
            end
            default: state <= ST_HOLD;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         delayCount <= '0;
      else if (state != ST_DELAY || delayDone)
         delayCount <= '0;
      else
         delayCount <= delayCount + 1'b1;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         resetKind <= KIND_POR;
      else
         resetKind <= next_kind;
   end

   // a hardware reset event wins over a software clear in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         statusFlags <= 2'h0;
      end else if (pinEvent) begin
         // pin while running keeps both flags
         if (powerDownMode)
            statusFlags <= 2'h1;
      end else if (tripEvent) begin
         statusFlags <= statusFlags;
      end else if (wdogEvent) begin
         statusFlags.expired <= 1'b1;
         if (powerDownMode)
            statusFlags.powerdown <= 1'b1;
      end else if (haltEnter) begin
         statusFlags <= 2'h1;
      end else if (flagClear) begin
         statusFlags <= 2'h0;
      end
   end

   // values and mask are loaded once, as the core is released
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         resetLoad <= 1'b0;
         loadMask  <= '0;
         regValues <= '0;
      end else begin
         resetLoad <= delayDone;
         if (delayDone) begin
            regValues.pcLow       <= PC_LOW_RESET;
            regValues.wdogSetting <= WDOG_SETTING_RESET;
            regValues.irqCtrl     <= IRQ_CTRL_RESET;
            regValues.count0      <= COUNT_VALUE_RESET;
            regValues.count1      <= COUNT_VALUE_RESET;
            regValues.count0Ctrl  <= COUNT_CTRL_RESET;
            regValues.count1Ctrl  <= COUNT_CTRL_RESET;
            regValues.portA       <= PORT_RESET;
            regValues.portADir    <= PORT_RESET;
            regValues.prescale    <= PRESCALE_RESET;
            if (resetKind == KIND_WDOG_HALT) begin
               regValues.sp <= SP_CLEAR;
               loadMask     <= MASK_CORE;
            end else begin
               regValues.sp <= SP_TOP;
               loadMask     <= MASK_ALL;
            end
         end
      end
   end

   assign coreRun       = (state == ST_RUN);
   assign watchdogClear = resetLoad;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   chk_ports_inputs: assert property (
      resetLoad && loadMask.ports |->
         regValues.portA == PORT_RESET && regValues.portADir == PORT_RESET)
      else $error("port registers not loaded as inputs");

   chk_hold_while_low: assert property (
      !pinHigh |=> !coreRun ##1 !coreRun)
      else $error("core ran while clear pin low");

   chk_delay_before_run: assert property (
      $rose(coreRun) |->
         $past(state) == ST_DELAY && $past(delayCount) == DELAY_LAST)
      else $error("core released before start delay elapsed");

   chk_restart_zero: assert property (
      $rose(coreRun) |-> resetLoad && regValues.pcLow == PC_LOW_RESET)
      else $error("program counter not cleared at release");

   chk_wdog_run_flag: assert property (
      wdogEvent && !powerDownMode |=>
         statusFlags.expired && state == ST_DELAY && !coreRun)
      else $error("running watchdog reset mishandled");

   chk_wdog_halt: assert property (
      resetLoad && resetKind == KIND_WDOG_HALT |->
         regValues.sp == SP_CLEAR && loadMask == MASK_CORE
         && statusFlags == 2'h3)
      else $error("halt watchdog wake mishandled");

   chk_pin_flags: assert property (
      (pinEvent && !powerDownMode) || tripEvent |=>
         statusFlags == $past(statusFlags))
      else $error("pin or trip reset changed status flags");

   chk_halt_pin_flags: assert property (
      pinEvent && powerDownMode |=> statusFlags == 2'b01)
      else $error("pin reset from halt gave wrong flags");

   chk_irq_off: assert property (
      resetLoad && resetKind == KIND_POR |->
         loadMask.irqCtrl && regValues.irqCtrl == IRQ_CTRL_RESET
         && regValues.sp == SP_TOP)
      else $error("interrupts not disabled after power-on");

   chk_wdog_restart: assert property (
      $rose(coreRun) |-> watchdogClear ##1 !watchdogClear)
      else $error("watchdog not cleared once at release");

   chk_timer_load: assert property (
      resetLoad && resetKind != KIND_WDOG_HALT |->
         loadMask.timers && loadMask.prescale && loadMask.wdogSetting
         && regValues.count0Ctrl == COUNT_CTRL_RESET
         && regValues.count1 == COUNT_VALUE_RESET
         && regValues.wdogSetting == WDOG_SETTING_RESET)
      else $error("timer or watchdog setting not loaded");

endmodule : reset_source_sequencer

// ---- verif/clear_switch_model.sv ----
// external clear pin model: reset switch with a pull-up on the pin
`timescale 1ns/1ps
module clear_switch_model (
   input  wire logic clk,
   input  wire logic press,
   output logic      pinN
);
   // power-on network holds the pin low until the bench lets go
   initial pinN = 1'b0;
   // pull-up: a released pin returns high, never keeps a stale level
   always @(posedge clk) begin
      pinN <= !press;
   end
endmodule : clear_switch_model

// ---- verif/reset_source_sequencer_bench.sv ----
// self-checking bench for the reset source sequencer
`timescale 1ns/1ps
module reset_source_sequencer_bench;
   import reset_seq_pkg::*;
   localparam int DLY = 4;
   localparam regValues_type FULL = '{pcLow: PC_LOW_RESET, sp: SP_TOP,
      wdogSetting: WDOG_SETTING_RESET, irqCtrl: IRQ_CTRL_RESET,
      count0: COUNT_VALUE_RESET, count0Ctrl: COUNT_CTRL_RESET,
      count1: COUNT_VALUE_RESET, count1Ctrl: COUNT_CTRL_RESET,
      portA: PORT_RESET, portADir: PORT_RESET, prescale: PRESCALE_RESET};
   logic            clk = 1'b0;
   logic            resetn = 1'b0;
   logic            press = 1'b1;
   logic            pinN;
   logic            lvt = 1'b0;
   logic            wdog = 1'b0;
   logic            pdm = 1'b0;
   logic            halt = 1'b0;
   logic            fclr = 1'b0;
   logic            coreRun;
   logic            resetLoad;
   logic            watchdogClear;
   loadMask_type    loadMask;
   regValues_type   regValues;
   statusFlags_type statusFlags;
   resetKind_type   resetKind;
   int              errCount = 0;
   int              checked = 0;
   int              cycles = 0;

   clear_switch_model u_pin (.clk(clk), .press(press), .pinN(pinN));
   reset_source_sequencer #(.DELAY_CYCLES(DLY)) u_dut (
      .clk(clk), .resetn(resetn), .externalClearPinN(pinN),
      .lowVoltageTrip(lvt), .watchdogTimeout(wdog), .powerDownMode(pdm),
      .haltEnter(halt), .flagClear(fclr), .coreRun(coreRun),
      .resetLoad(resetLoad), .watchdogClear(watchdogClear),
      .loadMask(loadMask), .regValues(regValues),
      .statusFlags(statusFlags), .resetKind(resetKind));

   always #20 clk = ~clk;
   // ceiling well above the hundred or so cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errCount++;
         finish_test();
      end
   end

   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   task automatic check(input string what, input logic [90:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         errCount++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // waits for the release pulse; it must land after exactly expN edges:
   // pin path is model 1 + sync 2 + hold exit 1 + DLY, watchdog just DLY
   task automatic wait_load(input loadMask_type mask,
                            input logic [1:0] flags, input resetKind_type k,
                            input int expN);
      int n;
      n = 0;
      do begin
         step();
         n++;
      end while (resetLoad !== 1'b1 && n < 100);
      check("delay", n, expN);
      check("load", {resetLoad, coreRun}, 2'b11);
      check("wdclr", watchdogClear, 1'b1);
      check("mask", loadMask, mask);
      check("pcl", regValues.pcLow, PC_LOW_RESET);
      check("flags", statusFlags, flags);
      check("kind", resetKind, k);
      step();
      check("pulse", {resetLoad, watchdogClear}, 2'b00);
   endtask : wait_load

   // power-on, also mid-run: flags left set must come back cleared
   task automatic test_por();
      resetn = 1'b0;
      press = 1'b1;
      repeat (16) step();
      resetn = 1'b1;
      repeat (5) step();
      check("hold", coreRun, 1'b0);
      press = 1'b0;
      wait_load(MASK_ALL, 2'b00, KIND_POR, DLY + 4);
      check("values", regValues, FULL);
   endtask : test_por

   task automatic test_wdog_run();
      fclr = 1'b1;
      step();
      fclr = 1'b0;
      wdog = 1'b1;
      step();
      wdog = 1'b0;
      check("wdstop", coreRun, 1'b0);
      wait_load(MASK_ALL, 2'b10, KIND_WDOG_RUN, DLY);
      check("wdvals", regValues, FULL);
   endtask : test_wdog_run

   // pin or low-voltage trip while running leaves the flags alone
   task automatic test_ext_run(input logic useLvr, input resetKind_type k);
      if (useLvr) lvt = 1'b1;
      else press = 1'b1;
      repeat (5) step();
      check("extstop", coreRun, 1'b0);
      lvt = 1'b0;
      press = 1'b0;
      wait_load(MASK_ALL, 2'b10, k, useLvr ? DLY + 1 : DLY + 4);
   endtask : test_ext_run

   // pin case clears the flags first, so 01 can only come from the pin
   task automatic test_halt(input logic useWdog);
      halt = useWdog;
      fclr = !useWdog;
      pdm = 1'b1;
      step();
      halt = 1'b0;
      fclr = 1'b0;
      if (useWdog) begin
         wdog = 1'b1;
         step();
         wdog = 1'b0;
         wait_load(MASK_CORE, 2'b11, KIND_WDOG_HALT, DLY);
      end else begin
         press = 1'b1;
         repeat (4) step();
         press = 1'b0;
         wait_load(MASK_ALL, 2'b01, KIND_PIN_HALT, DLY + 4);
      end
      check("sp", regValues.sp, useWdog ? SP_CLEAR : SP_TOP);
      pdm = 1'b0;
   endtask : test_halt

   task automatic finish_test();
      $display("mismatches %0d of %0d checks", errCount, checked);
      if (errCount == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   initial begin
      test_por();
      test_wdog_run();
      test_ext_run(1'b0, KIND_PIN_RUN);
      test_ext_run(1'b1, KIND_LOWV);
      test_halt(1'b1);
      test_halt(1'b0);
      test_por();
      finish_test();
   end
endmodule : reset_source_sequencer_bench
